// file: rtl/cie_core.v
/*
 * Instruction execute core of an 8-bit microcontroller: decodes 14-bit
 * instruction words and executes them on the accumulator, flags, stack and
 * file registers, with an APB slave for run control and state readback.
 * Assumes program memory answers pmem_data one clock after pmem_addr, and the
 * file register memory answers file_rdata one clock after file_addr; both
 * inputs are synchronous to pclk.
 */
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "cie_consts.vh"

module cie_core #(
    parameter STACK_DEPTH = 8,
    parameter SP_W        = 3
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [12:0] pmem_addr,
    input  wire [13:0] pmem_data,
    output reg  [6:0]  file_addr,
    input  wire [7:0]  file_rdata,
    output reg  [7:0]  file_wdata,
    output reg         file_we,
    input  wire        wake,
    output reg         watchdog_clear,
    output reg         global_interrupt_enable,
    output reg         sleeping
);

    // Adder returning {carry, digit carry, sum}
    function [9:0] alu_add;
        input [7:0] a;
        input [7:0] b;
        input       cin;
        reg   [4:0] lo;
        reg   [8:0] full;
        begin
            lo      = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            full    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            alu_add = {full[8], lo[4], full[7:0]};
        end
    endfunction

    reg [1:0]     phase_reg;
    reg [13:0]    ir_reg;
    reg [7:0]     acc_reg;
    reg [12:0]    pc_reg;
    reg [4:0]     pc_high_latch_reg;
    reg           c_reg;
    reg           digit_carry_reg;
    reg           z_reg;
    reg           timeout_status_bit_reg;
    reg           powerdown_status_bit_reg;
    reg           nop_cycle_reg;
    reg           run_reg;
    reg [SP_W-1:0] sp_reg;
    reg [12:0]    stack_mem [0:STACK_DEPTH-1];

    reg [7:0]     acc_next;
    reg [12:0]    pc_next;
    reg           c_next;
    reg           digit_carry_next;
    reg           z_next;
    reg           fwe_next;
    reg [7:0]     fdata_next;
    reg           two_cycle;
    reg           push_op;
    reg           pop_op;
    reg           gie_set;
    reg           wdog_op;
    reg           sleep_op;

    wire [6:0]  f_addr   = ir_reg[`CIE_F_MSB:0];
    wire        dest_f   = ir_reg[`CIE_D_BIT];
    wire [2:0]  bit_idx  = ir_reg[`CIE_B_LSB+2:`CIE_B_LSB];
    wire [7:0]  lit8     = ir_reg[7:0];
    wire [12:0] pc_inc   = pc_reg + 13'h0001;
    wire [12:0] pc_jump  = {pc_high_latch_reg[`CIE_LATCH_HI:`CIE_LATCH_LO],
                            ir_reg[`CIE_K11_MSB:0]};
    wire [12:0] stack_top = stack_mem[sp_reg - {{(SP_W-1){1'b0}}, 1'b1}];
    wire        exec_en  = (phase_reg == `CIE_PHASE_EXEC) && run_reg && !sleeping;
    wire [9:0]  add_res  = alu_add(acc_reg, file_rdata, 1'b0);
    wire [9:0]  sub_res  = alu_add(file_rdata, ~acc_reg, 1'b1);
    wire [9:0]  addl_res = alu_add(acc_reg, lit8, 1'b0);
    wire [9:0]  subl_res = alu_add(lit8, ~acc_reg, 1'b1);
    wire [7:0]  f_inc    = file_rdata + 8'h01;
    wire [7:0]  f_dec    = file_rdata - 8'h01;
    wire [7:0]  bit_mask = 8'h01 << bit_idx;

    // Decode and execute one instruction word
    always @* begin
        acc_next   = acc_reg;
        pc_next    = pc_inc;
        c_next     = c_reg;
        digit_carry_next = digit_carry_reg;
        z_next     = z_reg;
        fwe_next   = 1'b0;
        fdata_next = 8'h00;
        two_cycle  = 1'b0;
        push_op    = 1'b0;
        pop_op     = 1'b0;
        gie_set    = 1'b0;
        wdog_op    = 1'b0;
        sleep_op   = 1'b0;
        casez (ir_reg[13:12])
            2'b00: begin
                // Byte-oriented group; result goes to file or accumulator
                case (ir_reg[13:8])
                    `CIE_OP_ADDF: begin
                        fdata_next = add_res[7:0];
                        {c_next, digit_carry_next} = add_res[9:8];
                    end
                    `CIE_OP_SUBF: begin
                        fdata_next = sub_res[7:0];
                        {c_next, digit_carry_next} = sub_res[9:8];
                    end
                    `CIE_OP_ANDF: fdata_next = acc_reg & file_rdata;
                    `CIE_OP_IORF: fdata_next = acc_reg | file_rdata;
                    `CIE_OP_XORF: fdata_next = acc_reg ^ file_rdata;
                    `CIE_OP_MOVE: fdata_next = file_rdata;
                    `CIE_OP_COMP: fdata_next = ~file_rdata;
                    `CIE_OP_INC: fdata_next = f_inc;
                    `CIE_OP_DEC: fdata_next = f_dec;
                    `CIE_OP_INCSZ: begin
                        fdata_next = f_inc;
                        two_cycle  = (f_inc == 8'h00);
                    end
                    `CIE_OP_DECSZ: begin
                        fdata_next = f_dec;
                        two_cycle  = (f_dec == 8'h00);
                    end
                    `CIE_OP_ROL: {c_next, fdata_next} = {file_rdata, c_reg};
                    `CIE_OP_ROR: {fdata_next, c_next} = {c_reg, file_rdata};
                    `CIE_OP_SWAP: fdata_next = {file_rdata[3:0], file_rdata[7:4]};
                    `CIE_OP_CLR: fdata_next = 8'h00;
                    default: fdata_next = acc_reg;
                endcase
                // Zero flag for the operations that affect it
                case (ir_reg[13:8])
                    `CIE_OP_ADDF, `CIE_OP_SUBF, `CIE_OP_ANDF, `CIE_OP_IORF,
                    `CIE_OP_XORF, `CIE_OP_MOVE, `CIE_OP_COMP, `CIE_OP_INC,
                    `CIE_OP_DEC, `CIE_OP_CLR:
                        z_next = (fdata_next == 8'h00);
                    default: z_next = z_reg;
                endcase
                // Destination routing; clear and store follow bit 7 as form select
                if (ir_reg[13:8] == `CIE_OP_MISC) begin
                    if (ir_reg[7]) begin
                        fwe_next = 1'b1;
                    end else begin
                        case (ir_reg[7:0])
                            `CIE_W_RETURN: begin
                                pop_op    = 1'b1;
                                pc_next   = stack_top;
                                two_cycle = 1'b1;
                            end
                            `CIE_W_IRET: begin
                                pop_op    = 1'b1;
                                pc_next   = stack_top;
                                gie_set   = 1'b1;
                                two_cycle = 1'b1;
                            end
                            `CIE_W_SLEEP:  sleep_op = 1'b1;
                            `CIE_W_WDCLR: wdog_op   = 1'b1;
                            default: ;
                        endcase
                    end
                end else if (dest_f) begin
                    fwe_next = 1'b1;
                end else begin
                    acc_next = fdata_next;
                end
            end
            2'b01: begin
                // Bit-oriented group
                case (ir_reg[11:10])
                    2'b00: begin
                        fdata_next = file_rdata & ~bit_mask;
                        fwe_next   = 1'b1;
                    end
                    2'b01: begin
                        fdata_next = file_rdata | bit_mask;
                        fwe_next   = 1'b1;
                    end
                    2'b10: two_cycle = ((file_rdata & bit_mask) == 8'h00);
                    default: two_cycle = ((file_rdata & bit_mask) != 8'h00);
                endcase
            end
            2'b10: begin
                // Call and branch load the 11-bit target plus latch bits
                pc_next   = pc_jump;
                push_op   = !ir_reg[11];
                two_cycle = 1'b1;
            end
            default: begin
                // Literal group
                casez (ir_reg[11:8])
                    4'b00??: acc_next = lit8;
                    4'b01??: begin
                        acc_next  = lit8;
                        pop_op    = 1'b1;
                        pc_next   = stack_top;
                        two_cycle = 1'b1;
                    end
                    4'b1000: acc_next = acc_reg | lit8;
                    4'b1001: acc_next = acc_reg & lit8;
                    4'b1010: acc_next = acc_reg ^ lit8;
                    4'b110?: begin
                        acc_next = subl_res[7:0];
                        {c_next, digit_carry_next} = subl_res[9:8];
                    end
                    4'b111?: begin
                        acc_next = addl_res[7:0];
                        {c_next, digit_carry_next} = addl_res[9:8];
                    end
                    default: acc_next = acc_reg;
                endcase
                if (ir_reg[11:10] != 2'b00 && ir_reg[11:10] != 2'b01 &&
                    ir_reg[11:8] != 4'b1011) begin
                    z_next = (acc_next == 8'h00);
                end
            end
        endcase
        // Skips advance past the discarded word
        if (two_cycle && !push_op && !pop_op && ir_reg[13] == 1'b0) begin
            pc_next = pc_reg + 13'h0002;
        end
    end

    // APB slave: one wait state, write commits on the completing edge
    wire bus_access = psel && penable;
    wire wr_commit  = bus_access && pready && pwrite;
    wire addr_hit   = (paddr == `CIE_CTRL_OFF) || (paddr == `CIE_STAT_OFF) ||
                      (paddr == `CIE_ACC_OFF) || (paddr == `CIE_PC_OFF) ||
                      (paddr == `CIE_LATCH_OFF);

    // Phase counter, instruction latch and execute state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg                <= 2'd0;
            ir_reg                   <= 14'h0000;
            acc_reg                  <= 8'h00;
            pc_reg                   <= `CIE_PC_RST;
            pmem_addr                <= `CIE_PC_RST;
            c_reg                    <= 1'b0;
            digit_carry_reg          <= 1'b0;
            z_reg                    <= 1'b0;
            timeout_status_bit_reg   <= `CIE_TMO_RST;
            powerdown_status_bit_reg <= `CIE_PWRDN_RST;
            nop_cycle_reg            <= 1'b0;
            sp_reg                   <= {SP_W{1'b0}};
            file_addr                <= 7'h00;
            file_wdata               <= 8'h00;
            file_we                  <= 1'b0;
            watchdog_clear           <= 1'b0;
            global_interrupt_enable  <= 1'b0;
            sleeping                 <= 1'b0;
        end else begin
            phase_reg      <= phase_reg + 2'd1;
            file_we        <= 1'b0;
            watchdog_clear <= 1'b0;
            if (phase_reg == `CIE_PHASE_FETCH) begin
                ir_reg    <= pmem_data;
                file_addr <= pmem_data[`CIE_F_MSB:0];
            end
            if (exec_en && nop_cycle_reg) begin
                nop_cycle_reg <= 1'b0;
            end else if (exec_en) begin
                acc_reg       <= acc_next;
                pc_reg        <= pc_next;
                pmem_addr     <= pc_next;
                c_reg         <= c_next;
                digit_carry_reg <= digit_carry_next;
                z_reg         <= z_next;
                nop_cycle_reg <= two_cycle;
                file_we       <= fwe_next;
                file_wdata    <= fdata_next;
                if (push_op) begin
                    stack_mem[sp_reg] <= pc_inc;
                    sp_reg            <= sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
                end
                if (pop_op) begin
                    sp_reg <= sp_reg - {{(SP_W-1){1'b0}}, 1'b1};
                end
                if (gie_set) begin
                    global_interrupt_enable <= 1'b1;
                end
                if (wdog_op || sleep_op) begin
                    watchdog_clear         <= 1'b1;
                    timeout_status_bit_reg <= 1'b1;
                end
                if (wdog_op) begin
                    powerdown_status_bit_reg <= 1'b1;
                end
                if (sleep_op) begin
                    powerdown_status_bit_reg <= 1'b0;
                    sleeping                 <= 1'b1;
                end
            end else if (wake || (wr_commit && paddr == `CIE_CTRL_OFF &&
                                  pwdata[`CIE_CTRL_WAKE])) begin
                sleeping <= 1'b0;
            end
        end
    end

    // Register bank: pready one cycle after the first access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            prdata            <= 32'h00000000;
            run_reg           <= 1'b0;
            pc_high_latch_reg <= 5'h00;
        end else begin
            pready  <= bus_access && !pready;
            pslverr <= bus_access && !pready && !addr_hit;
            if (bus_access && !pready && !pwrite) begin
                case (paddr)
                    `CIE_CTRL_OFF:  prdata <= {31'h00000000, run_reg};
                    `CIE_STAT_OFF:  prdata <= {25'h0000000, sleeping,
                                               global_interrupt_enable,
                                               powerdown_status_bit_reg,
                                               timeout_status_bit_reg,
                                               z_reg, digit_carry_reg, c_reg};
                    `CIE_ACC_OFF:   prdata <= {24'h000000, acc_reg};
                    `CIE_PC_OFF:    prdata <= {19'h00000, pc_reg};
                    `CIE_LATCH_OFF: prdata <= {27'h0000000, pc_high_latch_reg};
                    default:        prdata <= 32'h00000000;
                endcase
            end
            if (wr_commit && paddr == `CIE_CTRL_OFF) begin
                run_reg <= pwdata[`CIE_CTRL_RUN];
            end
            if (wr_commit && paddr == `CIE_LATCH_OFF) begin
                pc_high_latch_reg <= pwdata[4:0];
            end
        end
    end

endmodule // cie_core

// file: rtl/cie_consts.vh
/*
 * Constants of the instruction execute core: register offsets, reset values,
 * field positions, opcode patterns and timing counts.
 * Assumes inclusion by bare name from the core and its assertion checker.
 */
`ifndef CIE_CONSTS_VH
`define CIE_CONSTS_VH

// Clock periods per instruction cycle
`define CIE_PHASES          3'd4
`define CIE_PHASE_FETCH     2'd1
`define CIE_PHASE_EXEC      2'd3

// Register offsets (byte addresses)
`define CIE_CTRL_OFF        12'h000
`define CIE_STAT_OFF        12'h004
`define CIE_ACC_OFF         12'h008
`define CIE_PC_OFF          12'h00C
`define CIE_LATCH_OFF       12'h010

// Control fields
`define CIE_CTRL_RUN        0
`define CIE_CTRL_WAKE       1

// Status field positions
`define CIE_ST_C            0
`define CIE_ST_DIGIT        1
`define CIE_ST_Z            2
`define CIE_ST_TMO          3
`define CIE_ST_PWRDN        4
`define CIE_ST_IEN          5
`define CIE_ST_SLEEP        6

// Reset values
`define CIE_PC_RST          13'h0000
`define CIE_TMO_RST         1'b1
`define CIE_PWRDN_RST       1'b1

// Instruction field positions
`define CIE_F_MSB           6
`define CIE_D_BIT           7
`define CIE_B_LSB           7
`define CIE_K11_MSB         10
`define CIE_LATCH_HI        4
`define CIE_LATCH_LO        3

// Byte-oriented opcodes, instruction bits 13:8
`define CIE_OP_MISC         6'h00
`define CIE_OP_CLR          6'h01
`define CIE_OP_SUBF         6'h02
`define CIE_OP_DEC          6'h03
`define CIE_OP_IORF         6'h04
`define CIE_OP_ANDF         6'h05
`define CIE_OP_XORF         6'h06
`define CIE_OP_ADDF         6'h07
`define CIE_OP_MOVE         6'h08
`define CIE_OP_COMP         6'h09
`define CIE_OP_INC          6'h0A
`define CIE_OP_DECSZ        6'h0B
`define CIE_OP_ROR          6'h0C
`define CIE_OP_ROL          6'h0D
`define CIE_OP_SWAP         6'h0E
`define CIE_OP_INCSZ        6'h0F

// Control words with no operand, instruction bits 7:0 when bits 13:8 are zero
`define CIE_W_RETURN        8'h08
`define CIE_W_IRET          8'h09
`define CIE_W_SLEEP         8'h63
`define CIE_W_WDCLR         8'h64

`endif

// file: sim/cie_core_assertions.sv
/*
 * Port checker for the instruction execute core: APB handshake, pulse
 * widths, instruction cycle pacing and sleep hold.
 * Assumes binding onto cie_core and a single pclk domain.
 */
`timescale 1ns/1ps
`include "cie_consts.vh"

module cie_core_assertions (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic [11:0] paddr,
    input logic        pready,
    input logic        pslverr,
    input logic [12:0] pmem_addr,
    input logic        file_we,
    input logic        wake,
    input logic        watchdog_clear,
    input logic        global_interrupt_enable,
    input logic        sleeping
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Decoded register window
    wire mapped = paddr == `CIE_CTRL_OFF || paddr == `CIE_STAT_OFF || paddr == `CIE_ACC_OFF ||
                  paddr == `CIE_PC_OFF || paddr == `CIE_LATCH_OFF;

    // Setup cycle followed by the first access cycle
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence

    a_apb_wait_state: assert property (s_access |=> pready)
        else $error("pready late after access");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_unmapped_error: assert property (s_access ##0 !mapped |=> pready && pslverr)
        else $error("no error on unmapped address");
    a_mapped_no_error: assert property (s_access ##0 mapped |=> !pslverr)
        else $error("error on mapped address");
    a_write_pacing: assert property (file_we |=> !file_we [*3])
        else $error("file writes closer than one instruction");
    a_wdog_pulse: assert property (watchdog_clear |=> !watchdog_clear [*3])
        else $error("watchdog clear too long");
    a_pc_pacing: assert property ($changed(pmem_addr) |=> $stable(pmem_addr) [*3])
        else $error("program counter moved within a cycle");
    a_enable_sticky: assert property (global_interrupt_enable |=> global_interrupt_enable)
        else $error("interrupt enable dropped");
    a_sleep_halt: assert property (sleeping && !wake |=> $stable(pmem_addr))
        else $error("program counter moved while asleep");
endmodule // cie_core_assertions

bind cie_core cie_core_assertions i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr), .file_we(file_we),
    .wake(wake), .watchdog_clear(watchdog_clear),
    .global_interrupt_enable(global_interrupt_enable), .sleeping(sleeping)
);

// file: sim/cie_mem_model.sv
/*
 * Program memory and file register model for the execute core.
 * Assumes one clock of read latency on both ports, writes on file_we.
 */
`timescale 1ns/1ps

module cie_mem_model (
    input  logic        pclk,
    input  logic [12:0] pmem_addr,
    output logic [13:0] pmem_data,
    input  logic [6:0]  file_addr,
    output logic [7:0]  file_rdata,
    input  logic [7:0]  file_wdata,
    input  logic        file_we
);
    logic [13:0] prog [0:8191];
    logic [7:0]  regs [0:127];

    // Empty program and cleared files
    initial begin
        for (int i = 0; i < 8192; i++) prog[i] = 14'h0000;
        for (int i = 0; i < 128; i++) regs[i] = 8'h00;
    end

    // Registered reads, write on strobe
    always @(posedge pclk) begin
        pmem_data <= prog[pmem_addr];
        file_rdata <= regs[file_addr];
        if (file_we) regs[file_addr] <= file_wdata;
    end
endmodule // cie_mem_model

// file: sim/cie_tb.sv
/*
 * Testbench: runs a program over the memory model and checks state over APB.
 * Assumes cie_core, its checker and the memory model are compiled before it.
 */
`timescale 1ns/1ps

module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wake = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, file_we, watchdog_clear, global_interrupt_enable, sleeping, er;
    logic [12:0] pmem_addr;
    logic [13:0] pmem_data;
    logic [6:0] file_addr;
    logic [7:0] file_rdata, file_wdata;
    int n_errors = 0, comparisons = 0, cyc = 0, n_we = 0, n_wdc = 0;
    logic [13:0] main_w [25] = '{14'h309C, 14'h3E75, 14'h00A0, 14'h07A0, 14'h3C11, 14'h0920,
        14'h06A0, 14'h0AA0, 14'h17A0, 14'h1FA0, 14'h3055, 14'h0D20, 14'h2030, 14'h0EA1,
        14'h0BA2, 14'h30AA, 14'h0064, 14'h13A0, 14'h02A1, 14'h0821, 14'h01A2, 14'h0100,
        14'h03A1, 14'h0063, 14'h2FFF};
    logic [13:0] sub_w [10] = '{14'h38F0, 14'h2034, 14'h345A, 14'h0000, 14'h3AFF, 14'h2038,
        14'h0008, 14'h0000, 14'h390C, 14'h0009};

    cie_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .file_addr(file_addr), .file_rdata(file_rdata), .file_wdata(file_wdata),
        .file_we(file_we), .wake(wake), .watchdog_clear(watchdog_clear),
        .global_interrupt_enable(global_interrupt_enable), .sleeping(sleeping));
    cie_mem_model i_mem (.pclk(pclk), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .file_addr(file_addr), .file_rdata(file_rdata), .file_wdata(file_wdata),
        .file_we(file_we));

    // Clock, timeout and strobe counters
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (file_we === 1'b1) n_we++;
        if (watchdog_clear === 1'b1) n_wdc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report;
        end
    end

    task final_report;
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 25; i++) i_mem.prog[i] = main_w[i];
        for (int i = 0; i < 10; i++) i_mem.prog[13'h830 + i] = sub_w[i];
        i_mem.prog[13'h0FFF] = 14'h2FFF;
        i_mem.regs[7'h21] = 8'h3C;
        i_mem.regs[7'h22] = 8'h01;
        rdc(12'h004, 32'h18);
        rdc(12'h00C, 32'h0);
        apb(0, 12'h020, 0);
        chk(er, 1);
        chk(rd, 0);
        apb(1, 12'h010, 32'h08);
        rdc(12'h010, 32'h08);
        apb(1, 12'h000, 32'h1);
        for (int n = 0; n < 2000 && sleeping !== 1'b1; n++) @(posedge pclk);
        chk(sleeping, 1);
        rdc(12'h004, 32'h69);
        chk(n_wdc, 2);
        @(posedge pclk) wake <= 1;
        @(posedge pclk) wake <= 0;
        for (int n = 0; n < 2000 && pmem_addr !== 13'h0FFF; n++) @(posedge pclk);
        repeat (8) @(posedge pclk);
        rdc(12'h00C, 32'h0FFF);
        rdc(12'h004, 32'h29);
        rdc(12'h008, 32'h00);
        chk(i_mem.regs[7'h20], 8'h00);
        chk(i_mem.regs[7'h21], 8'h68);
        chk(i_mem.regs[7'h22], 8'h00);
        chk(n_we, 11);
        final_report;
    end
endmodule // testbench
